/* File: rbs_pkg.sv */
// Package for the random byte source register block
package rbs_pkg;
  localparam logic [31:0] RBS_ADDR_HW_STATUS = 32'hFFBC015F;
  localparam logic [31:0] RBS_ADDR_DATA_STATUS = 32'hFFBC0160;
  localparam logic [31:0] RBS_ADDR_DATA_BYTE = 32'hFFBC0161;
  localparam int RBS_PRESENT_BIT = 6;
  localparam int RBS_ENABLE_BIT = 0;
  localparam int RBS_VALID_BIT = 0;
  localparam logic [7:0] RBS_DATA_STATUS_RST = 8'h00;
  localparam logic [7:0] RBS_DATA_BYTE_RST = 8'h40;
  localparam logic [7:0] RBS_ZERO_BYTE = 8'h00;
  localparam logic [2:0] RBS_BIT_LAST = 3'h7;
  localparam logic [2:0] RBS_BIT_FIRST = 3'h0;
  localparam logic [15:0] RBS_LFSR_SEED = 16'hACE1;
  localparam logic [15:0] RBS_LFSR_TAPS = 16'hB400;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [31:0] addr;
    logic [7:0]  wdata;
  } rbs_req_t;

  typedef struct packed {
    logic        en;
    logic        valid;
    logic [7:0]  data;
    logic [7:0]  shift;
    logic [2:0]  cnt;
    logic [7:0]  rdata;
    logic        rvalid;
  } rbs_state_t;

  typedef struct packed {
    logic [15:0] lfsr;
    logic        bit_out;
    logic        bit_vld;
  } rbs_src_t;
endpackage

/* File: rbs_bit_source.sv */
// Bit source: one bit per cycle while running, frozen otherwise
`timescale 1ns/1ps
module rbs_bit_source (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control
  input wire logic run,
  // Bit stream
  output logic bit_out,
  output logic bit_vld
);
  import rbs_pkg::*;
  rbs_src_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.bit_vld = 1'b0;
    if (run) begin
      s_d.lfsr = {1'b0, s_q.lfsr[15:1]} ^ (s_q.lfsr[0] ? RBS_LFSR_TAPS : 16'h0000);
      s_d.bit_out = s_q.lfsr[0];
      s_d.bit_vld = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_q <= '{lfsr: RBS_LFSR_SEED, bit_out: 1'b0, bit_vld: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign bit_out = s_q.bit_out;
  assign bit_vld = s_q.bit_vld;

  a_idle_no_bits: assert property (@(posedge clk) disable iff (!rst_b)
    !run |=> !bit_vld) else $error("Bit produced while idle");
endmodule

/* File: rbs_top.sv */
// Random byte source register block
// Operation
// - Hardware status bit 6 reads 1 whenever a source is present, whether enabled or disabled.
// - Hardware status bit 0 is read and write, 1 starts generation and 0 stops it.
// - Data status bit 0 reads 1 while a valid byte is held, and resets to 00h.
// - The data register is read only, holds the latest byte, and resets to 40h.
// - The generator sits idle in low power while not producing bits.
// - When enabled, bits shift one at a time into eight bits, then valid is set.
// - A data read clears valid at once and a fresh byte is gathered.
`timescale 1ns/1ps
module rbs_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Configuration
  input wire logic src_present,
  // Register access
  input rbs_pkg::rbs_req_t req,
  output logic [7:0] rdata,
  output logic rvalid
);
  import rbs_pkg::*;
  rbs_state_t st_q, st_d;
  logic run;
  logic bit_out;
  logic bit_vld;
  logic rd_data;

  assign rd_data = req.rd && (req.addr == RBS_ADDR_DATA_BYTE);

  assign run = st_q.en && src_present && !st_q.valid;

  rbs_bit_source u_src (
    .clk(clk),
    .rst_b(rst_b),
    .run(run),
    .bit_out(bit_out),
    .bit_vld(bit_vld)
  );

  always_comb begin
    st_d = st_q;
    st_d.rvalid = req.rd;
    if (req.wr && req.addr == RBS_ADDR_HW_STATUS) begin
      st_d.en = req.wdata[RBS_ENABLE_BIT];
    end
    if (bit_vld && run) begin
      st_d.shift = {st_q.shift[6:0], bit_out};
      st_d.cnt = st_q.cnt + 3'h1;
      if (st_q.cnt == RBS_BIT_LAST) begin
        st_d.data = {st_q.shift[6:0], bit_out};
        st_d.valid = 1'b1;
        st_d.cnt = RBS_BIT_FIRST;
      end
    end
    if (rd_data) begin
      st_d.valid = 1'b0;
    end
    if (!st_q.en || !src_present) begin
      st_d.cnt = RBS_BIT_FIRST;
    end
    st_d.rdata = RBS_ZERO_BYTE;
    if (req.rd) begin
      unique case (req.addr)
        RBS_ADDR_HW_STATUS: begin
          st_d.rdata[RBS_PRESENT_BIT] = src_present;
          st_d.rdata[RBS_ENABLE_BIT] = st_q.en;
        end
        RBS_ADDR_DATA_STATUS: begin
          st_d.rdata[RBS_VALID_BIT] = st_q.valid;
        end
        RBS_ADDR_DATA_BYTE: begin
          st_d.rdata = st_q.data;
        end
        default: begin
          st_d.rdata = RBS_ZERO_BYTE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q <= '{en: 1'b0, valid: RBS_DATA_STATUS_RST[RBS_VALID_BIT], data: RBS_DATA_BYTE_RST,
                shift: RBS_ZERO_BYTE, cnt: RBS_BIT_FIRST, rdata: RBS_ZERO_BYTE, rvalid: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata = st_q.rdata;
  assign rvalid = st_q.rvalid;

  a_present_read: assert property (@(posedge clk) disable iff (!rst_b)
    req.rd && req.addr == RBS_ADDR_HW_STATUS
    |=> rdata[RBS_PRESENT_BIT] == $past(src_present))
    else $error("Presence bit wrong");

  a_enable_store: assert property (@(posedge clk) disable iff (!rst_b)
    req.wr && req.addr == RBS_ADDR_HW_STATUS
    |=> st_q.en == $past(req.wdata[RBS_ENABLE_BIT]))
    else $error("Enable not stored");

  a_status_read: assert property (@(posedge clk) disable iff (!rst_b)
    req.rd && req.addr == RBS_ADDR_DATA_STATUS
    |=> rdata == {7'h00, $past(st_q.valid)})
    else $error("Data status read wrong");

  a_data_read: assert property (@(posedge clk) disable iff (!rst_b)
    rd_data
    |=> rdata == $past(st_q.data))
    else $error("Data read wrong");

  a_valid_clear: assert property (@(posedge clk) disable iff (!rst_b)
    rd_data
    |=> !st_q.valid)
    else $error("Valid not cleared by read");

  a_valid_fill: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(st_q.valid)
    |-> $past(run) && $past(st_q.cnt) == RBS_BIT_LAST)
    else $error("Valid set early");

  a_absent_valid: assert property (@(posedge clk) disable iff (!rst_b)
    !src_present
    |=> !$rose(st_q.valid))
    else $error("Valid set when absent");

  a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_b)
    req.rd && req.addr == RBS_ADDR_HW_STATUS
    |=> rdata[7] == 1'b0 && rdata[5:1] == 5'h00)
    else $error("Reserved bits nonzero");

  a_no_spurious_rv: assert property (@(posedge clk) disable iff (!rst_b)
    rvalid
    |-> $past(req.rd))
    else $error("Read answer without request");

  a_rvalid_pulse: assert property (@(posedge clk) disable iff (!rst_b)
    req.rd
    |=> rvalid)
    else $error("Read not answered");

  a_idle_rdata_zero: assert property (@(posedge clk) disable iff (!rst_b)
    !req.rd
    |=> rdata == RBS_ZERO_BYTE)
    else $error("Read data not zero when idle");

  a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_b)
    req.rd && req.addr != RBS_ADDR_HW_STATUS && req.addr != RBS_ADDR_DATA_STATUS && req.addr != RBS_ADDR_DATA_BYTE
    |=> rdata == RBS_ZERO_BYTE)
    else $error("Unmapped read not zero");

  a_en_hold: assert property (@(posedge clk) disable iff (!rst_b)
    !(req.wr && req.addr == RBS_ADDR_HW_STATUS)
    |=> $stable(st_q.en))
    else $error("Enable changed without write");

  a_hw_enable_read: assert property (@(posedge clk) disable iff (!rst_b)
    req.rd && req.addr == RBS_ADDR_HW_STATUS
    |=> rdata[RBS_ENABLE_BIT] == $past(st_q.en))
    else $error("Enable bit read wrong");

  a_cnt_idle: assert property (@(posedge clk) disable iff (!rst_b)
    !st_q.en
    |=> st_q.cnt == RBS_BIT_FIRST)
    else $error("Bit counter not cleared when stopped");

  a_run_absent: assert property (@(posedge clk) disable iff (!rst_b)
    !src_present
    |-> !run)
    else $error("Source running when absent");

  a_valid_hold: assert property (@(posedge clk) disable iff (!rst_b)
    st_q.valid && !rd_data
    |=> st_q.valid)
    else $error("Valid dropped without read");

  a_shift_frozen: assert property (@(posedge clk) disable iff (!rst_b)
    !run
    |=> $stable(st_q.shift))
    else $error("Holding byte moved while idle");

  // Data byte changes only on completion
  a_data_update: assert property (@(posedge clk) disable iff (!rst_b)
    $changed(st_q.data)
    |-> $rose(st_q.valid) || $past(rd_data))
    else $error("Data byte changed without completion");

  c_byte_ready: cover property (@(posedge clk) disable iff (!rst_b) $rose(st_q.valid));
  c_absent_write: cover property (@(posedge clk) disable iff (!rst_b)
    !src_present && req.wr && req.addr == RBS_ADDR_HW_STATUS);
  c_read_valid: cover property (@(posedge clk) disable iff (!rst_b) rd_data && st_q.valid);
  c_enable: cover property (@(posedge clk) disable iff (!rst_b) $rose(st_q.en));
  c_disable: cover property (@(posedge clk) disable iff (!rst_b) $fell(st_q.en));
endmodule

/* File: rbs_top_tb_top.sv */
// Testbench for the random byte source register block
`timescale 1ns/1ps
module rbs_top_tb_top;
  import rbs_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic src_present = 1'b1;
  rbs_req_t req = '0;
  logic [7:0] rdata;
  logic rvalid;
  logic [7:0] v;
  int miscompares = 0;
  int compares = 0;
  rbs_top dut (.clk(clk), .rst_b(rst_b), .src_present(src_present), .req(req), .rdata(rdata), .rvalid(rvalid));
  always #50 clk = ~clk;
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd(input logic [31:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    chk("rvalid", 8'h01, {7'h00, rvalid});
    d = rdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] wv);
    @(posedge clk);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: wv};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic wait_valid(output logic [7:0] s);
    for (int i = 0; i < 40; i++) begin
      rd(RBS_ADDR_DATA_STATUS, s);
      if (s === 8'h01) break;
    end
  endtask
  task automatic reset_values();
    rd(RBS_ADDR_HW_STATUS, v);
    chk("hw_status", 8'h40, v);
    rd(RBS_ADDR_DATA_STATUS, v);
    chk("data_status", RBS_DATA_STATUS_RST, v);
    rd(RBS_ADDR_DATA_BYTE, v);
    chk("data_byte", RBS_DATA_BYTE_RST, v);
    rd(32'hFFBC0162, v);
    chk("unmapped", 8'h00, v);
    wr(RBS_ADDR_DATA_STATUS, 8'hFF);
    rd(RBS_ADDR_DATA_STATUS, v);
    chk("data_status_wr", 8'h00, v);
  endtask
  task automatic gen_and_clear();
    wr(RBS_ADDR_HW_STATUS, 8'hFF);
    rd(RBS_ADDR_HW_STATUS, v);
    chk("hw_enable", 8'h41, v);
    rd(RBS_ADDR_DATA_BYTE, v);
    wait_valid(v);
    chk("valid_set", 8'h01, v);
    rd(RBS_ADDR_DATA_BYTE, v);
    rd(RBS_ADDR_DATA_STATUS, v);
    chk("valid_clear", 8'h00, v);
    wait_valid(v);
    chk("valid_again", 8'h01, v);
    rd(RBS_ADDR_DATA_BYTE, v);
    rd(RBS_ADDR_DATA_STATUS, v);
    chk("valid_clear_again", 8'h00, v);
  endtask
  task automatic disable_stop();
    rd(RBS_ADDR_DATA_BYTE, v);
    wr(RBS_ADDR_HW_STATUS, 8'h00);
    rd(RBS_ADDR_HW_STATUS, v);
    chk("hw_disable", 8'h40, v);
    repeat (20) @(posedge clk);
    rd(RBS_ADDR_DATA_STATUS, v);
    chk("stopped", 8'h00, v);
  endtask
  task automatic absent();
    @(posedge clk);
    src_present <= 1'b0;
    rd(RBS_ADDR_HW_STATUS, v);
    chk("present", 8'h00, v & 8'h40);
    wr(RBS_ADDR_HW_STATUS, 8'h01);
    repeat (20) @(posedge clk);
    rd(RBS_ADDR_DATA_STATUS, v);
    chk("absent_valid", 8'h00, v);
  endtask
  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    reset_values();
    gen_and_clear();
    disable_stop();
    absent();
    results();
  end
  // Watchdog cuts a hang short
  initial begin
    #100000;
    miscompares++;
    results();
  end
endmodule
